// ===== smg_cfg.svh
// Constants for the sync marker generator: offsets, fields, resets, timing
`ifndef SMG_CFG_SVH
`define SMG_CFG_SVH
// Register byte offsets
`define SMG_CTRL_OFF     8'h00
`define SMG_DUTY_OFF     8'h04
`define SMG_STAT_OFF     8'h08
// Control register fields
`define SMG_CTRL_EN_BIT  0
`define SMG_CTRL_MODE_LO 4
`define SMG_CTRL_MODE_HI 6
// Reset values
`define SMG_CTRL_RST     32'h00000000
`define SMG_DUTY_RST     7'h32
// Minimum pulse width: 200 ns; stretch strictly longer
`define SMG_PULSE_NS     200
`define SMG_CLK_MHZ      250
`define SMG_PULSE_CYC    ((`SMG_PULSE_NS * `SMG_CLK_MHZ + 999) / 1000 + 1)
`define SMG_DUTY_MAX     7'h64
`endif

// ===== smg_pkg.sv
// Types for the sync marker generator
package smg_pkg;
  typedef enum logic [2:0] {
    SMG_PERIODIC,
    SMG_ARB,
    SMG_MOD,
    SMG_BURST_CNT,
    SMG_BURST_GATE,
    SMG_FSK,
    SMG_SWEEP
  } smg_mode_t;
  // Status flags of the waveform engine
  typedef struct packed {
    logic positive;
    logic first_sample;
    logic mod_zero_cross;
    logic burst_active;
    logic fsk_hop;
    logic sweep_start;
    logic sweep_end;
  } smg_engine_t;
endpackage

// ===== smg_stretch.sv
// Pulse stretcher holding a marker high past the minimum width
`timescale 1ns/1ps
`include "smg_cfg.svh"
module smg_stretch (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Trigger and stretched pulse
  input  wire logic trig,
  output logic      pulse
);
  logic [7:0] count;
  // Reload on each trigger, count down to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (trig) begin
      count <= 8'(`SMG_PULSE_CYC);
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end
  assign pulse = (count != 8'h00);
endmodule

// ===== smg_axil.sv
// AXI4-Lite slave carrying the marker control, duty and status words
`timescale 1ns/1ps
`include "smg_cfg.svh"
module smg_axil (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register contents and status
  output logic [31:0]      ctrl,
  output logic [6:0]       duty,
  input  wire logic [31:0] status
);
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         do_write = aw_held && w_held && !bvalid;
  wire         hit_ctrl = (aw_addr == `SMG_CTRL_OFF);
  wire         hit_duty = (aw_addr == `SMG_DUTY_OFF);
  wire         wr_ok    = hit_ctrl || hit_duty || (aw_addr == `SMG_STAT_OFF);
  wire [6:0]   duty_in  = (w_data[6:0] > `SMG_DUTY_MAX) ? `SMG_DUTY_MAX : w_data[6:0];
  wire [31:0]  rd_word  = (araddr == `SMG_CTRL_OFF) ? ctrl :
                          (araddr == `SMG_DUTY_OFF) ? {25'h0, duty} :
                          (araddr == `SMG_STAT_OFF) ? status : 32'h00000000;
  wire         rd_ok    = (araddr == `SMG_CTRL_OFF) || (araddr == `SMG_DUTY_OFF) ||
                          (araddr == `SMG_STAT_OFF);
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end
  // Register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= `SMG_CTRL_RST;
      duty   <= `SMG_DUTY_RST;
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? 2'h0 : 2'h2;
        if (hit_ctrl && w_strb[0]) begin
          ctrl[7:0] <= w_data[7:0];
        end
        if (hit_duty && w_strb[0]) begin
          duty <= duty_in;
        end
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // Read response, one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= 2'h0;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ===== smg_top.sv
// Sync marker generator top: mode selection, marker register, assertions
//
// Behaviour
// - With marker disabled the line level is unspecified; here it is held low.
// - Periodic functions: marker high when waveform above offset, low below.
// - Arbitrary waveform: pulse over 200 ns at first stored sample.
// - AM/FM: pulse over 200 ns at each modulating zero crossing.
// - Counted burst: low during burst, high after count until next burst.
// - Gated burst: marker follows output sign relative to offset.
// - FSK: pulse over 200 ns at each switch to hop frequency.
// - Sweep: low at sweep start, high at sweep end; here a start and an end in the same cycle give one high cycle, then low.
// - Marker enable sits in volatile register cleared by reset.
// - Duty setting is a percentage high time, square waves only.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "smg_cfg.svh"
module smg_top (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Waveform engine
  input  wire smg_pkg::smg_engine_t engine,
  input  wire logic                square_sel,
  input  wire logic [6:0]          phase_pct,
  // Outputs
  output logic                     sync_out,
  output logic                     square_high,
  output logic [6:0]               duty_pct
);
  logic [31:0]         ctrl;
  logic [6:0]          duty;
  logic                swept_high;
  logic                burst_done;
  logic                burst_prev;
  logic                pulse;
  wire  [31:0]         status;
  wire                 marker_en;
  wire  [2:0]          mode_bits;
  smg_pkg::smg_mode_t  mode;
  wire                 pulse_trig;
  logic                next_sync;
  wire                 pulse_mode;
  logic [7:0]          run_hi;

  // Control decode
  assign marker_en = ctrl[`SMG_CTRL_EN_BIT];
  assign mode_bits = ctrl[`SMG_CTRL_MODE_HI:`SMG_CTRL_MODE_LO];
  assign mode      = smg_pkg::smg_mode_t'(mode_bits);
  assign status    = {25'h0, pulse, burst_done, swept_high, square_high,
                      sync_out, engine.positive, marker_en};
  // Marker enabled in one of the pulse-type modes
  assign pulse_mode = marker_en && ((mode == smg_pkg::SMG_ARB) || (mode == smg_pkg::SMG_MOD) ||
                                    (mode == smg_pkg::SMG_FSK));

  smg_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .ctrl    (ctrl),
    .duty    (duty),
    .status  (status)
  );

  // Pulse triggers of the pulse-type modes
  // first sample, zero crossing and hop triggers
  assign pulse_trig = ((mode == smg_pkg::SMG_ARB)   && engine.first_sample) ||
                      ((mode == smg_pkg::SMG_MOD)   && engine.mod_zero_cross) ||
                      ((mode == smg_pkg::SMG_FSK)   && engine.fsk_hop);

  smg_stretch u_stretch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (pulse_trig),
    .pulse   (pulse)
  );

  // Burst completion and sweep phase tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_prev <= 1'b0;
      burst_done <= 1'b0;
      swept_high <= 1'b0;
    end else begin
      burst_prev <= engine.burst_active;
      if (engine.burst_active) begin
        burst_done <= 1'b0;
      end else if (burst_prev) begin
        burst_done <= 1'b1;
      end
      if (engine.sweep_start) begin
        swept_high <= 1'b0;
      end else if (engine.sweep_end) begin
        swept_high <= 1'b1;
      end
    end
  end

  // Marker selection by mode
  always_comb begin
    next_sync = 1'b0;
    case (mode)
      smg_pkg::SMG_PERIODIC:   next_sync = engine.positive;
      smg_pkg::SMG_BURST_GATE: next_sync = engine.positive;
      smg_pkg::SMG_BURST_CNT:  next_sync = burst_done && !engine.burst_active;
      smg_pkg::SMG_SWEEP:      next_sync = engine.sweep_end ||
                                           (swept_high && !engine.sweep_start);
      smg_pkg::SMG_ARB,
      smg_pkg::SMG_MOD,
      smg_pkg::SMG_FSK:        next_sync = pulse || pulse_trig;
      default:                 next_sync = 1'b0;
    endcase
    if (!marker_en) begin
      next_sync = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= next_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      square_high <= 1'b0;
      duty_pct    <= `SMG_DUTY_RST;
    end else begin
      square_high <= square_sel && (phase_pct < duty);
      duty_pct    <= duty;
    end
  end

  // Assertions
  property p_sign;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_PERIODIC)) |=> (sync_out == $past(engine.positive));
  endproperty
  a_sign: assert property (p_sign) else $error("marker not following sign");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_BURST_GATE)) |=> (sync_out == $past(engine.positive));
  endproperty
  a_gate: assert property (p_gate) else $error("gated marker wrong");

  // Length of the current stretched pulse, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_hi <= 8'h00;
    end else if (!pulse) begin
      run_hi <= 8'h00;
    end else if (run_hi != 8'hff) begin
      run_hi <= run_hi + 8'h01;
    end
  end

  // pulse ends only after minimum width
  sequence s_pulse_end;
    $past(aresetn) && $fell(pulse);
  endsequence
  property p_pulse_width;
    @(posedge aclk) disable iff (!aresetn)
      s_pulse_end |-> (run_hi >= 8'(`SMG_PULSE_CYC));
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");

  property p_pulse_hi;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && pulse_trig && (mode == smg_pkg::SMG_ARB)) ##1
      (marker_en && (mode == smg_pkg::SMG_ARB)) [*8] |-> sync_out;
  endproperty
  a_pulse_hi: assert property (p_pulse_hi) else $error("arb pulse too short");

  property p_stretch;
    @(posedge aclk) disable iff (!aresetn)
      pulse_trig |=> pulse [*8];
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch too short");

  property p_mod_pulse;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_MOD) && engine.mod_zero_cross) |=> sync_out;
  endproperty
  a_mod_pulse: assert property (p_mod_pulse) else $error("no zero cross pulse");

  property p_fsk_pulse;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_FSK) && engine.fsk_hop) |=> sync_out;
  endproperty
  a_fsk_pulse: assert property (p_fsk_pulse) else $error("no hop pulse");

  property p_burst_low;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_BURST_CNT) && engine.burst_active) |=> !sync_out;
  endproperty
  a_burst_low: assert property (p_burst_low) else $error("marker high in burst");

  property p_sweep;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_SWEEP) && engine.sweep_start) |=> !sync_out;
  endproperty
  a_sweep: assert property (p_sweep) else $error("marker high at sweep start");

  property p_off;
    @(posedge aclk) disable iff (!aresetn)
      !marker_en |=> !sync_out;
  endproperty
  a_off: assert property (p_off) else $error("marker driven while off");

  property p_duty;
    @(posedge aclk) disable iff (!aresetn)
      !square_sel |=> !square_high;
  endproperty
  a_duty: assert property (p_duty) else $error("duty used off square");

  property p_volatile;
    @(posedge aclk)
      !aresetn |=> !marker_en;
  endproperty
  a_volatile: assert property (p_volatile) else $error("enable survived reset");

  property p_arb_pulse;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_ARB) && engine.first_sample) |=> sync_out;
  endproperty
  a_arb_pulse: assert property (p_arb_pulse) else $error("no first sample pulse");

  property p_mod_width;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_MOD) && engine.mod_zero_cross) ##1
      (marker_en && (mode == smg_pkg::SMG_MOD)) [*8] |-> sync_out;
  endproperty
  a_mod_width: assert property (p_mod_width) else $error("zero cross pulse too short");

  property p_fsk_width;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_FSK) && engine.fsk_hop) ##1
      (marker_en && (mode == smg_pkg::SMG_FSK)) [*8] |-> sync_out;
  endproperty
  a_fsk_width: assert property (p_fsk_width) else $error("hop pulse too short");

  property p_pulse_idle;
    @(posedge aclk) disable iff (!aresetn)
      (pulse_mode && !pulse && !pulse_trig) |=> !sync_out;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("pulse marker high when idle");

  property p_burst_high;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_BURST_CNT) && burst_done && !engine.burst_active)
      |=> sync_out;
  endproperty
  a_burst_high: assert property (p_burst_high) else $error("marker low after burst");

  property p_burst_clr;
    @(posedge aclk) disable iff (!aresetn)
      engine.burst_active |=> !burst_done;
  endproperty
  a_burst_clr: assert property (p_burst_clr) else $error("burst done set in burst");

  property p_sweep_end;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_SWEEP) && engine.sweep_end && !engine.sweep_start)
      |=> sync_out;
  endproperty
  a_sweep_end: assert property (p_sweep_end) else $error("marker low at sweep end");

  property p_sweep_hold;
    @(posedge aclk) disable iff (!aresetn)
      (marker_en && (mode == smg_pkg::SMG_SWEEP) && swept_high && !engine.sweep_start &&
       !engine.sweep_end) |=> sync_out;
  endproperty
  a_sweep_hold: assert property (p_sweep_hold) else $error("sweep end level lost");

  property p_square_on;
    @(posedge aclk) disable iff (!aresetn)
      (square_sel && (phase_pct < duty)) |=> square_high;
  endproperty
  a_square_on: assert property (p_square_on) else $error("square low inside duty");

  property p_square_off;
    @(posedge aclk) disable iff (!aresetn)
      (square_sel && (phase_pct >= duty)) |=> !square_high;
  endproperty
  a_square_off: assert property (p_square_off) else $error("square high past duty");

  property p_duty_max;
    @(posedge aclk) disable iff (!aresetn)
      duty_pct <= `SMG_DUTY_MAX;
  endproperty
  a_duty_max: assert property (p_duty_max) else $error("duty above full scale");
endmodule

// ===== smg_ttl_rx.sv
// Behavioural TTL receiver measuring marker high times
`timescale 1ns/1ps
module smg_ttl_rx (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Marker line and measurements
  input  wire logic        sync_in,
  output logic      [15:0] width,
  output logic      [7:0]  pulses
);
  logic [15:0] run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run    <= 16'h0000;
      width  <= 16'h0000;
      pulses <= 8'h00;
    end else if (sync_in) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      width  <= run;
      pulses <= pulses + 8'h01;
      run    <= 16'h0000;
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench for the sync marker generator
`timescale 1ns/1ps
`include "smg_cfg.svh"
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  smg_pkg::smg_engine_t engine;
  logic        square_sel, sync_out, square_high;
  logic [6:0]  phase_pct, duty_pct;
  logic [15:0] width;
  logic [7:0]  pulses;
  int          n_mismatch, checks_done;

  // Design and receiver
  smg_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .engine(engine), .square_sel(square_sel), .phase_pct(phase_pct), .sync_out(sync_out),
    .square_high(square_high), .duty_pct(duty_pct));
  smg_ttl_rx u_rx (.aclk(aclk), .aresetn(aresetn), .sync_in(sync_out), .width(width),
    .pulses(pulses));

  // Clock generator
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task timeout();
    n_mismatch++;
    $display("CHECK FAILED bus wait expected answer seen timeout");
    complete_run();
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (n > 100) timeout();
    end
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (n > 100) timeout();
    end
  endtask

  task set_ctrl(input logic [2:0] m, input logic en);
    axi_wr(`SMG_CTRL_OFF, {25'h0, m, 3'h0, en}, rs);
  endtask

  task pulse_bit(input int b);
    @(posedge aclk);
    engine[b] <= 1'b1;
    @(posedge aclk);
    engine[b] <= 1'b0;
    #1;
  endtask

  task t_reset();
    chk("sync_out", 0, sync_out);
    chk("duty_pct", `SMG_DUTY_RST, duty_pct);
    axi_rd(`SMG_CTRL_OFF, rd, rs);
    chk("ctrl", `SMG_CTRL_RST, rd);
    axi_rd(`SMG_DUTY_OFF, rd, rs);
    chk("duty", {25'h0, `SMG_DUTY_RST}, rd);
    $display("test reset done");
  endtask

  task t_level();
    for (int m = 0; m < 5; m += 4) begin
      set_ctrl(3'(m), 1'b1);
      @(posedge aclk);
      engine.positive <= 1'b1;
      @(posedge aclk);
      #1;
      chk("sync high", 1, sync_out);
      axi_rd(`SMG_STAT_OFF, rd, rs);
      chk("stat", 32'h7, rd & 32'h7);
      @(posedge aclk);
      engine.positive <= 1'b0;
      @(posedge aclk);
      #1;
      chk("sync low", 0, sync_out);
    end
    set_ctrl(3'h0, 1'b0);
    @(posedge aclk);
    engine.positive <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk("sync off", 0, sync_out);
    @(posedge aclk);
    engine.positive <= 1'b0;
    $display("test level done");
  endtask

  task t_pulse();
    int md[3];
    int bt[3];
    logic [7:0] p;
    md = '{1, 2, 5};
    bt = '{5, 4, 2};
    for (int i = 0; i < 3; i++) begin
      set_ctrl(3'(md[i]), 1'b1);
      repeat (3) @(posedge aclk);
      p = pulses;
      pulse_bit(bt[i]);
      repeat (80) @(posedge aclk);
      #1;
      chk("width", `SMG_PULSE_CYC + 1, 32'(width));
      chk("over 200ns", 1, 32'(width) * 4 > 200);
      chk("pulses", 32'(p) + 1, 32'(pulses));
    end
    $display("test pulse done");
  endtask

  task t_burst();
    set_ctrl(3'h3, 1'b1);
    @(posedge aclk);
    engine.burst_active <= 1'b1;
    repeat (6) @(posedge aclk);
    #1;
    chk("burst low", 0, sync_out);
    @(posedge aclk);
    engine.burst_active <= 1'b0;
    repeat (6) @(posedge aclk);
    #1;
    chk("burst done", 1, sync_out);
    @(posedge aclk);
    engine.burst_active <= 1'b1;
    @(posedge aclk);
    #1;
    chk("burst again", 0, sync_out);
    @(posedge aclk);
    engine.burst_active <= 1'b0;
    $display("test burst done");
  endtask

  task t_sweep();
    set_ctrl(3'h6, 1'b1);
    pulse_bit(0);
    chk("sweep end", 1, sync_out);
    repeat (5) @(posedge aclk);
    #1;
    chk("end held", 1, sync_out);
    pulse_bit(1);
    chk("sweep start", 0, sync_out);
    repeat (5) @(posedge aclk);
    #1;
    chk("start held", 0, sync_out);
    $display("test sweep done");
  endtask

  task sq(input logic s, input logic [6:0] ph, input logic e);
    @(posedge aclk);
    square_sel <= s;
    phase_pct  <= ph;
    @(posedge aclk);
    #1;
    chk("square_high", e, square_high);
  endtask

  task t_duty();
    axi_wr(`SMG_DUTY_OFF, 32'h19, rs);
    axi_rd(`SMG_DUTY_OFF, rd, rs);
    chk("duty", 32'h19, rd);
    chk("duty_pct", 32'h19, duty_pct);
    sq(1'b1, 7'h18, 1'b1);
    sq(1'b1, 7'h19, 1'b0);
    sq(1'b0, 7'h0a, 1'b0);
    axi_wr(`SMG_DUTY_OFF, 32'h78, rs);
    axi_rd(`SMG_DUTY_OFF, rd, rs);
    chk("duty clip", 32'h64, rd);
    $display("test duty done");
  endtask

  task t_bus();
    axi_rd(8'h0c, rd, rs);
    chk("rresp", 2, rs);
    chk("rdata", 0, rd);
    axi_wr(8'h0c, 32'h1, rs);
    chk("bresp", 2, rs);
    axi_wr(`SMG_STAT_OFF, 32'hff, rs);
    chk("stat wr", 0, rs);
    set_ctrl(3'h2, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SMG_CTRL_OFF, rd, rs);
    chk("ctrl reset", 0, rd);
    $display("test bus done");
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, square_sel} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    engine = '0;
    phase_pct = 7'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    t_reset();
    t_level();
    t_pulse();
    t_burst();
    t_sweep();
    t_duty();
    t_bus();
    complete_run();
  end
endmodule
